// ===== rtl/bsp_defines.svh
// Purpose: register offsets, field positions and counts for the serial port
// Assumes: included by its bare name
// Notes:   definitions only
`ifndef BSP_DEFINES_SVH
`define BSP_DEFINES_SVH
`define BSP_A_RXLO   5'h00
`define BSP_A_RXHI   5'h01
`define BSP_A_TXLO   5'h02
`define BSP_A_TXHI   5'h03
`define BSP_A_CTRL   5'h04
`define BSP_A_SRG2   5'h05
`define BSP_A_PIN    5'h06
`define BSP_A_MC1    5'h07
`define BSP_A_MC2    5'h08
`define BSP_A_STAT   5'h09
`define BSP_A_RXCE   2'h2
`define BSP_A_TXCE   2'h3
`define BSP_F_WIDE   9
`define BSP_F_SRCM   13
`define BSP_F_PINSRC 7
`define BSP_F_RXDIR  0
`define BSP_F_TXDIR  1
`define BSP_F_EN     0
`define BSP_F_STOP   1
`define BSP_F_SPIM   2
`define BSP_F_WL_HI  6
`define BSP_F_WL_LO  4
`define BSP_F_DIV_HI 7
`define BSP_RST16    16'h0000
`define BSP_CH_LEG   8'h20
`define BSP_CH_WIDE  8'h80
`define BSP_CE_REGS  8
`endif

// ===== rtl/bsp_pkg.sv
// Purpose: shared types of the serial port
// Assumes: nothing
// Notes:   source code is {pin source select, source mode}
`default_nettype none
package bsp_pkg;
	typedef enum logic [1:0] {
		BSP_SRC_NONE = 2'h0,
		BSP_SRC_CPU  = 2'h1,
		BSP_SRC_RXP  = 2'h2,
		BSP_SRC_TXP  = 2'h3
	} bsp_src_t;
	typedef enum logic [1:0] {
		BSP_L_IDLE = 2'h0,
		BSP_L_RUN  = 2'h1,
		BSP_L_HOLD = 2'h3
	} bsp_lst_t;
	function automatic logic [5:0] bsp_wlen(input logic [2:0] code);
		case (code)
			3'h0:    bsp_wlen = 6'h08;
			3'h1:    bsp_wlen = 6'h0C;
			3'h2:    bsp_wlen = 6'h10;
			3'h3:    bsp_wlen = 6'h14;
			3'h4:    bsp_wlen = 6'h18;
			default: bsp_wlen = 6'h20;
		endcase
	endfunction : bsp_wlen
endpackage : bsp_pkg
`default_nettype wire

// ===== rtl/bsp_link_if.sv
// Purpose: bundle between register side and link side
// Assumes: config fields change only while the port is disabled
// Notes:   toggles carry events, words are held stable around them
`default_nettype none
interface bsp_link_if;
	logic         cfg_en;
	logic         wide_rx;
	logic         wide_tx;
	logic         stop;
	logic [2:0]   wlen_code;
	logic [127:0] rx_ce;
	logic [127:0] tx_ce;
	logic [31:0]  tx_word;
	logic         tx_tgl;
	logic [31:0]  rx_word;
	logic         rx_tgl;
	modport sys  (output cfg_en, wide_rx, wide_tx, stop, wlen_code, rx_ce, tx_ce, tx_word, tx_tgl,
	              input rx_word, rx_tgl);
	modport link (input cfg_en, wide_rx, wide_tx, stop, wlen_code, rx_ce, tx_ce, tx_word, tx_tgl,
	              output rx_word, rx_tgl);
endinterface : bsp_link_if
`default_nettype wire

// ===== rtl/bsp_link.sv
// Purpose: shifter and channel sequencer on the serial clock
// Assumes: frame sync and data in are launched on clk_link by the peer
// Notes:   purely edge driven, so any slow or stopped clock is fine
`default_nettype none
`include "bsp_defines.svh"
module bsp_link
	import bsp_pkg::*;
(
	input  wire logic clk_link,
	input  wire logic rst,
	input  wire logic din,
	input  wire logic fs,
	output logic      dout,
	output logic      dout_oe_n,
	bsp_link_if.link  lk
);
	logic [1:0]  rst_s;
	logic [1:0]  en_s;
	logic [2:0]  tt_s;
	bsp_lst_t    st;
	logic [5:0]  bit_cnt;
	logic [7:0]  chan;
	logic [31:0] rx_sh;
	logic [31:0] tx_sh;
	logic [31:0] tx_pend;
	logic [31:0] rx_word;
	logic        rx_tgl;
	wire         rst_l   = rst_s[1];
	wire  [5:0]  wl      = bsp_wlen(lk.wlen_code);
	wire         wend    = (st == BSP_L_RUN) && (bit_cnt == wl - 6'h01);
	wire  [7:0]  rx_lim  = lk.wide_rx ? `BSP_CH_WIDE : `BSP_CH_LEG;
	wire  [7:0]  tx_lim  = lk.wide_tx ? `BSP_CH_WIDE : `BSP_CH_LEG;
	wire  [7:0]  lim     = (rx_lim > tx_lim) ? rx_lim : tx_lim;
	wire  [7:0]  nchan   = fs ? 8'h00 : chan + 8'h01;
	wire         last    = lk.stop || (nchan == lim);
	wire         rx_on   = lk.stop || ((chan < rx_lim) && lk.rx_ce[chan[6:0]]);
	wire         tx_on   = lk.stop || ((nchan < tx_lim) && lk.tx_ce[nchan[6:0]]);
	wire  [31:0] mask    = (wl == 6'h20) ? 32'hFFFFFFFF : ((32'h1 << wl) - 32'h1);
	wire  [31:0] rx_full = {rx_sh[30:0], din} & mask;
	wire  [31:0] tx_alig = tx_pend << (6'h20 - wl);
	wire         start   = fs && en_s[1];
	wire         load    = start || (wend && !last);
	assign lk.rx_word = rx_word;
	assign lk.rx_tgl  = rx_tgl;

	// ************************************************************
	// reset and control crossings
	// ************************************************************
	always_ff @(posedge clk_link) begin
		rst_s <= {rst_s[0], rst};
		en_s  <= {en_s[0], lk.cfg_en};
		tt_s  <= {tt_s[1:0], lk.tx_tgl};
	end

	// ************************************************************
	// frame and word sequencing
	// ************************************************************
	always_ff @(posedge clk_link) begin
		if (rst_l) begin
			st      <= BSP_L_IDLE;
			bit_cnt <= 6'h00;
			chan    <= 8'h00;
			rx_sh   <= 32'h00000000;
			tx_sh   <= 32'h00000000;
			tx_pend <= 32'h00000000;
			rx_word <= 32'h00000000;
			rx_tgl  <= 1'b0;
			dout    <= 1'b0;
			dout_oe_n <= 1'b1;
		end else begin
			if (tt_s[2] ^ tt_s[1])
				tx_pend <= lk.tx_word;
			if (start) begin // R12
				st      <= BSP_L_RUN;
				bit_cnt <= 6'h00;
				chan    <= 8'h00;
			end else if (wend) begin
				bit_cnt <= 6'h00;
				chan    <= nchan;
				if (last)
					st <= BSP_L_HOLD; // R04
				if (rx_on) begin // R13
					rx_word <= rx_full;
					rx_tgl  <= ~rx_tgl;
				end
			end else if (st == BSP_L_RUN) begin
				bit_cnt <= bit_cnt + 6'h01;
			end
			rx_sh <= {rx_sh[30:0], din};
			if (load) begin
				dout      <= tx_on & tx_alig[31]; // R13
				tx_sh     <= tx_on ? (tx_alig << 1) : 32'h00000000; // R13
				dout_oe_n <= ~tx_on;
			end else if (st == BSP_L_RUN && !wend) begin
				dout  <= tx_sh[31];
				tx_sh <= tx_sh << 1;
			end else begin
				dout_oe_n <= 1'b1;
			end
		end
	end

	// ************************************************************
	// checks on the serial clock
	// ************************************************************
	a_legacy_chan: assert property (@(posedge clk_link) disable iff (rst_l) // R01
		(st == BSP_L_RUN && !lk.wide_rx && !lk.wide_tx) |-> chan < `BSP_CH_LEG)
		else $error("channel beyond legacy range");
	a_stop_single: assert property (@(posedge clk_link) disable iff (rst_l) // R04
		(lk.stop && st == BSP_L_RUN) |-> chan == 8'h00)
		else $error("clock stop frame holds more than one word");
	a_word_len: assert property (@(posedge clk_link) disable iff (rst_l) // R05
		(st == BSP_L_RUN) |-> bit_cnt < wl)
		else $error("bit count passes word length");
endmodule : bsp_link
`default_nettype wire

// ===== rtl/bsp_top.sv
// Purpose: multichannel buffered serial port with rate generator clock select
// Assumes: registers reached over a plain strobe port on clk_sys
// Notes:   link shifter runs on clk_link in bsp_link
//
// Contract
// R01: wide enable clear, the reset state, gives legacy 32-channel selection.
// R02: wide enable at bit 9 set allows selection among 128 channels.
// R03: wide mode uses twelve extra channel enable registers across both directions.
// R04: clock stop mode runs single-phase frames with exactly one word.
// R05: word length programmable to 8, 12, 16, 20, 24 or 32 bits.
// R06: in SPI mode transmitter and receiver are both master or both slave.
// R07: generator input from source mode and pin source: reserved, CPU, rx pin, tx pin.
// R08: a clock pin chosen as generator input has its output driver disabled.
// R09: both clock direction bits set run both sides from the generator.
// R10: with rx pin feeding the generator, output appears only on tx pin.
// R11: port logic is fully static, any low serial clock works.
// R12: multichannel frames are TDM streams with per-direction channel enables.
// R13: disabled channels are neither transmitted nor delivered to receive data. In clock stop mode the code ignores the enables and always passes the word.
//
// Added by the designer: the register offsets and the address-and-strobe port.
`default_nettype none
`include "bsp_defines.svh"
module bsp_top
	import bsp_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        clk_link,
	input  wire logic [4:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	input  wire logic        rx_serial_clock_pin_in,
	output logic             rx_serial_clock_pin_out,
	output logic             rx_serial_clock_pin_oe_n,
	input  wire logic        tx_serial_clock_pin_in,
	output logic             tx_serial_clock_pin_out,
	output logic             tx_serial_clock_pin_oe_n,
	input  wire logic        serial_data_in,
	input  wire logic        serial_frame_sync_in,
	output logic             serial_data_out,
	output logic             serial_data_oe_n
);
	bsp_link_if lk ();

	logic [15:0] ctrl;
	logic [15:0] rate_gen_config_reg_2;
	logic [15:0] pin_control_reg;
	logic [15:0] multichannel_ctrl_reg_1;
	logic [15:0] multichannel_ctrl_reg_2;
	logic [15:0] rx_ce [`BSP_CE_REGS];
	logic [15:0] tx_ce [`BSP_CE_REGS];
	logic [15:0] tx_hi;
	logic [31:0] tx_word;
	logic        tx_tgl;
	logic [31:0] rx_data;
	logic        rx_ready;
	logic [2:0]  rt_s;
	logic [1:0]  rxp_s;
	logic [1:0]  txp_s;
	logic        rxp_d;
	logic        txp_d;
	logic [7:0]  div_cnt;
	logic        srg_clk;

	// ************************************************************
	// decode
	// ************************************************************
	wire         wr_ce_rx = reg_wr && (reg_addr[4:3] == `BSP_A_RXCE);
	wire         wr_ce_tx = reg_wr && (reg_addr[4:3] == `BSP_A_TXCE);
	wire         rx_new   = rt_s[2] ^ rt_s[1];
	wire         stop     = ctrl[`BSP_F_STOP];
	wire         spi_m    = ctrl[`BSP_F_SPIM];
	wire         wide_rx  = multichannel_ctrl_reg_1[`BSP_F_WIDE];
	wire         wide_tx  = multichannel_ctrl_reg_2[`BSP_F_WIDE];
	wire         srg_pin_source_select = pin_control_reg[`BSP_F_PINSRC];
	wire         srg_source_mode       = rate_gen_config_reg_2[`BSP_F_SRCM];
	wire bsp_src_t src    = bsp_src_t'({srg_pin_source_select, srg_source_mode}); // R07
	wire         rx_clock_direction = stop ? spi_m : pin_control_reg[`BSP_F_RXDIR]; // R06
	wire         tx_clock_direction = stop ? spi_m : pin_control_reg[`BSP_F_TXDIR]; // R06
	wire         tick     = (src == BSP_SRC_CPU) ||
	                        ((src == BSP_SRC_RXP) && rxp_s[1] && !rxp_d) ||
	                        ((src == BSP_SRC_TXP) && txp_s[1] && !txp_d); // R07
	wire  [7:0]  div      = rate_gen_config_reg_2[`BSP_F_DIV_HI:0];
	wire         next_rx_oe_n = !(rx_clock_direction && (src != BSP_SRC_RXP)); // R08 R10
	wire         next_tx_oe_n = !(tx_clock_direction && (src != BSP_SRC_TXP)); // R08 R09
	wire  [15:0] stat     = {13'h0000, src, rx_ready};
	logic [15:0] next_rdata;

	always_comb begin
		case (reg_addr)
			`BSP_A_RXLO: next_rdata = rx_data[15:0];
			`BSP_A_RXHI: next_rdata = rx_data[31:16];
			`BSP_A_TXLO: next_rdata = tx_word[15:0];
			`BSP_A_TXHI: next_rdata = tx_hi;
			`BSP_A_CTRL: next_rdata = ctrl;
			`BSP_A_SRG2: next_rdata = rate_gen_config_reg_2;
			`BSP_A_PIN:  next_rdata = pin_control_reg;
			`BSP_A_MC1:  next_rdata = multichannel_ctrl_reg_1;
			`BSP_A_MC2:  next_rdata = multichannel_ctrl_reg_2;
			`BSP_A_STAT: next_rdata = stat;
			default: begin
				if (reg_addr[4:3] == `BSP_A_RXCE)
					next_rdata = rx_ce[reg_addr[2:0]];
				else if (reg_addr[4:3] == `BSP_A_TXCE)
					next_rdata = tx_ce[reg_addr[2:0]];
				else
					next_rdata = `BSP_RST16;
			end
		endcase
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctrl                    <= `BSP_RST16;
			rate_gen_config_reg_2   <= `BSP_RST16;
			pin_control_reg         <= `BSP_RST16;
			multichannel_ctrl_reg_1 <= `BSP_RST16; // R01
			multichannel_ctrl_reg_2 <= `BSP_RST16; // R01
			tx_hi                   <= `BSP_RST16;
			tx_word                 <= 32'h00000000;
			tx_tgl                  <= 1'b0;
		end else if (reg_wr) begin
			case (reg_addr)
				`BSP_A_CTRL: ctrl <= reg_wdata;
				`BSP_A_SRG2: rate_gen_config_reg_2 <= reg_wdata;
				`BSP_A_PIN:  pin_control_reg <= reg_wdata;
				`BSP_A_MC1:  multichannel_ctrl_reg_1 <= reg_wdata; // R02
				`BSP_A_MC2:  multichannel_ctrl_reg_2 <= reg_wdata; // R02
				`BSP_A_TXHI: tx_hi <= reg_wdata;
				`BSP_A_TXLO: begin
					tx_word <= {tx_hi, reg_wdata};
					tx_tgl  <= ~tx_tgl;
				end
				default: ;
			endcase
		end
	end

	// channel enables: two per direction for legacy, six more each in wide mode
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			for (int i = 0; i < `BSP_CE_REGS; i++) begin
				rx_ce[i] <= `BSP_RST16;
				tx_ce[i] <= `BSP_RST16;
			end
		end else begin
			if (wr_ce_rx)
				rx_ce[reg_addr[2:0]] <= reg_wdata; // R03
			if (wr_ce_tx)
				tx_ce[reg_addr[2:0]] <= reg_wdata; // R03
		end
	end

	// ************************************************************
	// receive delivery from the link domain
	// ************************************************************
	always_ff @(posedge clk_sys) begin
		rt_s <= {rt_s[1:0], lk.rx_tgl};
		if (rst) begin
			rx_data  <= 32'h00000000;
			rx_ready <= 1'b0;
		end else begin
			if (rx_new)
				rx_data <= lk.rx_word; // R13
			// a new word wins over the read that clears the flag
			if (rx_new)
				rx_ready <= 1'b1;
			else if (reg_rd && reg_addr == `BSP_A_RXLO)
				rx_ready <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst)
			reg_rdata <= `BSP_RST16;
		else
			reg_rdata <= reg_rd ? next_rdata : `BSP_RST16;
	end

	// ************************************************************
	// sample rate generator and clock pins
	// ************************************************************
	// pin clocks are oversampled, so they must stay below a third of clk_sys
	always_ff @(posedge clk_sys) begin
		rxp_s <= {rxp_s[0], rx_serial_clock_pin_in};
		txp_s <= {txp_s[0], tx_serial_clock_pin_in};
		rxp_d <= rxp_s[1];
		txp_d <= txp_s[1];
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			div_cnt                  <= 8'h00;
			srg_clk                  <= 1'b0;
			rx_serial_clock_pin_out  <= 1'b0;
			tx_serial_clock_pin_out  <= 1'b0;
			rx_serial_clock_pin_oe_n <= 1'b1;
			tx_serial_clock_pin_oe_n <= 1'b1;
		end else begin
			if (tick) begin // R07
				if (div_cnt >= div) begin
					div_cnt <= 8'h00;
					srg_clk <= ~srg_clk;
				end else begin
					div_cnt <= div_cnt + 8'h01;
				end
			end
			rx_serial_clock_pin_out  <= srg_clk; // R09
			tx_serial_clock_pin_out  <= srg_clk; // R09
			rx_serial_clock_pin_oe_n <= next_rx_oe_n; // R08 R10
			tx_serial_clock_pin_oe_n <= next_tx_oe_n; // R08
		end
	end

	// ************************************************************
	// link side
	// ************************************************************
	assign lk.cfg_en    = ctrl[`BSP_F_EN];
	assign lk.stop      = stop; // R04
	assign lk.wlen_code = ctrl[`BSP_F_WL_HI:`BSP_F_WL_LO]; // R05
	assign lk.wide_rx   = wide_rx; // R01 R02
	assign lk.wide_tx   = wide_tx;
	assign lk.rx_ce     = {rx_ce[7], rx_ce[6], rx_ce[5], rx_ce[4], rx_ce[3], rx_ce[2], rx_ce[1], rx_ce[0]};
	assign lk.tx_ce     = {tx_ce[7], tx_ce[6], tx_ce[5], tx_ce[4], tx_ce[3], tx_ce[2], tx_ce[1], tx_ce[0]};
	assign lk.tx_word   = tx_word;
	assign lk.tx_tgl    = tx_tgl;

	// bit and channel counters on the serial clock step only on its edges: it may stop between edges
	bsp_link u_link ( // R11
		.clk_link  (clk_link),
		.rst       (rst),
		.din       (serial_data_in),
		.fs        (serial_frame_sync_in),
		.dout      (serial_data_out),
		.dout_oe_n (serial_data_oe_n),
		.lk        (lk)
	);

	// ************************************************************
	// checks on the system clock
	// ************************************************************
	sequence s_rx_edge;
		rx_new;
	endsequence
	sequence s_rx_taken;
		##1 (rx_data == $past(lk.rx_word) && rx_ready);
	endsequence

	a_rx_deliver: assert property (@(posedge clk_sys) disable iff (rst) // R13
		s_rx_edge |-> s_rx_taken)
		else $error("received word not delivered");
	a_wide_reset: assert property (@(posedge clk_sys) // R01
		rst |=> !wide_rx && !wide_tx)
		else $error("wide selection set after reset");
	a_wide_set: assert property (@(posedge clk_sys) disable iff (rst) // R02
		(reg_wr && reg_addr == `BSP_A_MC1 && reg_wdata[`BSP_F_WIDE]) |=> wide_rx)
		else $error("wide selection not taken");
	a_rxpin_off: assert property (@(posedge clk_sys) disable iff (rst) // R08
		(src == BSP_SRC_RXP) [*2] |-> rx_serial_clock_pin_oe_n)
		else $error("rx pin driven while feeding generator");
	a_txpin_off: assert property (@(posedge clk_sys) disable iff (rst) // R08
		(src == BSP_SRC_TXP) [*2] |-> tx_serial_clock_pin_oe_n)
		else $error("tx pin driven while feeding generator");
	a_tx_only: assert property (@(posedge clk_sys) disable iff (rst) // R10
		(src == BSP_SRC_RXP && tx_clock_direction) [*2] |-> !tx_serial_clock_pin_oe_n)
		else $error("generator output missing on tx pin");
	a_both_srg: assert property (@(posedge clk_sys) disable iff (rst) // R09
		(src == BSP_SRC_CPU && rx_clock_direction && tx_clock_direction) |=>
		(!rx_serial_clock_pin_oe_n && !tx_serial_clock_pin_oe_n))
		else $error("both sides not on generator");
	a_spi_joint: assert property (@(posedge clk_sys) disable iff (rst) // R06
		(stop && src == BSP_SRC_CPU) |=> (rx_serial_clock_pin_oe_n == tx_serial_clock_pin_oe_n))
		else $error("spi roles differ");
	a_reserved_idle: assert property (@(posedge clk_sys) disable iff (rst) // R07
		(src == BSP_SRC_NONE) |=> $stable(srg_clk))
		else $error("generator runs from reserved source");
endmodule : bsp_top
`default_nettype wire

// ===== testbench/bsp_peer.sv
// Purpose: serial peer of the port: makes link clock, frame sync and receive data
// Assumes: peer is the clock master; the link clock stands still outside frames
// Notes:   captured transmit bits and enables are read by the bench per slot
`default_nettype none
module bsp_peer (
	output var logic clk_link,
	output var logic fs,
	output var logic din,
	input  wire logic dout,
	input  wire logic dout_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic q [0:511];
	logic e [0:511];
	initial begin
		clk_link = 1'b0;
		fs = 1'b0;
		din = 1'b0;
	end
	// 12 ns period, launches happen on the falling half so the port samples clean levels
	task automatic tick();
		#6 clk_link = 1'b1;
		#6 clk_link = 1'b0;
	endtask : tick
	task automatic idle(input int n);
		repeat (n) tick();
	endtask : idle
	// one sync pulse, then n bit slots; a clock-stop frame carries a single word
	task automatic frame(input int n, input logic [511:0] v);
		fs = 1'b0;
		idle(3);
		fs = 1'b1;
		din = ~din;
		tick();
		fs = 1'b0;
		for (int i = 0; i < n; i++) begin
			din = v[i];
			q[i] = dout;
			e[i] = dout_oe_n;
			tick();
		end
		// released line shows the inverse, so a stale bit never reads as good
		din = ~din;
	endtask : frame
endmodule : bsp_peer
`default_nettype wire

// ===== testbench/bsp_top_tb.sv
// Purpose: self-checking bench of the serial port with its clock source select
// Assumes: registers reached over the plain strobe port, peer drives the link
// Notes:   wide frames are 41 channels of 8 bits, so channel 40 is the last one
`default_nettype none
`include "bsp_defines.svh"
module bsp_top_tb
	import bsp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic         clk_sys = 1'b0;
	logic         rst = 1'b1;
	logic         clk_link, fs, din, dout, dout_oe_n;
	logic [4:0]   reg_addr = 5'h00;
	logic [15:0]  reg_wdata = 16'h0000;
	logic [15:0]  reg_rdata, d;
	logic         reg_wr = 1'b0;
	logic         reg_rd = 1'b0;
	logic         ext_clk = 1'b0;
	logic         rx_out, rx_oe_n, tx_out, tx_oe_n, last;
	wire          rx_pin = rx_oe_n ? ext_clk : rx_out;
	wire          tx_pin = tx_oe_n ? ext_clk : tx_out;
	int           miscompares = 0;
	int           cmp_count = 0;
	int           wl, cnt;
	int           lw [8] = '{8, 12, 16, 20, 24, 32, 32, 32};
	logic [31:0]  tw, rw, m, g;
	logic [511:0] v;
	bsp_src_t     s;

	always #12.5 clk_sys = ~clk_sys;

	bsp_top i_dut (.clk_sys(clk_sys), .rst(rst), .clk_link(clk_link), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.rx_serial_clock_pin_in(rx_pin), .rx_serial_clock_pin_out(rx_out), .rx_serial_clock_pin_oe_n(rx_oe_n),
		.tx_serial_clock_pin_in(tx_pin), .tx_serial_clock_pin_out(tx_out), .tx_serial_clock_pin_oe_n(tx_oe_n),
		.serial_data_in(din), .serial_frame_sync_in(fs), .serial_data_out(dout), .serial_data_oe_n(dout_oe_n));
	bsp_peer i_peer (.clk_link(clk_link), .fs(fs), .din(din), .dout(dout), .dout_oe_n(dout_oe_n));

	// ****************************************
	// access and compare tasks
	// ****************************************
	task automatic chk(input string n, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [15:0] dat);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= dat;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rchk(input string n, input logic [4:0] a, input logic [15:0] exp);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		chk(n, {16'h0000, exp}, {16'h0000, d});
	endtask : rchk
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	// sequence takes about 25 us; four times that means a hang
	initial begin
		#100000;
		miscompares++;
		tally_and_finish();
	end

	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		fork
			i_peer.idle(4);
		join_none
		repeat (6) @(posedge clk_sys);
		chk("pin_oe_n_rst", 32'h00000003, {30'h0, rx_oe_n, tx_oe_n});
		rst <= 1'b0;
		rchk("ctrl_rst", `BSP_A_CTRL, 16'h0000);
		rchk("mc1_rst", `BSP_A_MC1, 16'h0000);
		rchk("mc2_rst", `BSP_A_MC2, 16'h0000);
		wr(5'h0A, 16'hFFFF);
		rchk("unmapped", 5'h0A, 16'h0000);
		for (int k = 0; k < 4; k++) begin
			s = bsp_src_t'(k);
			wr(`BSP_A_SRG2, {2'h0, s[0], 5'h00, 8'h01});
			wr(`BSP_A_PIN, {8'h00, s[1], 5'h00, 2'h3});
			last = (s == BSP_SRC_TXP) ? rx_out : tx_out;
			cnt = 0;
			repeat (30) begin
				repeat (2) @(posedge clk_sys);
				ext_clk <= ~ext_clk;
				#1 if (((s == BSP_SRC_TXP) ? rx_out : tx_out) !== last) cnt++;
				last = (s == BSP_SRC_TXP) ? rx_out : tx_out;
			end
			chk("srg_running", {31'h0, s != BSP_SRC_NONE}, {31'h0, cnt != 0});
			chk("pin_oe_n", {30'h0, s == BSP_SRC_RXP, s == BSP_SRC_TXP}, {30'h0, rx_oe_n, tx_oe_n});
			rchk("src_code", `BSP_A_STAT, {13'h0000, s, 1'b0});
		end
		// clock-stop slave frames, one word each, all word length codes, generator on cpu clock
		s = BSP_SRC_CPU;
		wr(`BSP_A_SRG2, 16'h2001);
		wr(`BSP_A_PIN, 16'h0003);
		wr({`BSP_A_RXCE, 3'h0}, 16'h0001);
		wr({`BSP_A_TXCE, 3'h0}, 16'h0001);
		for (int c = 0; c < 8; c++) begin
			wl = lw[c];
			m = (wl == 32) ? 32'hFFFFFFFF : (32'h00000001 << wl) - 32'h00000001;
			tw = 32'hC3A55A3C ^ (32'h01010101 << c);
			rw = (32'h96E17B2D ^ (32'h00100401 << c)) & m;
			v = '0;
			for (int i = 0; i < wl; i++) v[i] = rw[wl - 1 - i];
			wr(`BSP_A_CTRL, 16'h0000);
			wr(`BSP_A_CTRL, {9'h000, 3'(c), 4'h2});
			wr(`BSP_A_TXHI, tw[31:16]);
			wr(`BSP_A_TXLO, tw[15:0]);
			wr(`BSP_A_CTRL, {9'h000, 3'(c), 4'h3});
			i_peer.frame(wl + 4, v);
			g = '0;
			cnt = 0;
			for (int i = 0; i < wl; i++) begin
				g = {g[30:0], i_peer.q[i]};
				if (i_peer.e[i] !== 1'b0) cnt++;
			end
			for (int i = wl; i < wl + 4; i++) if (i_peer.e[i] !== 1'b1) cnt++;
			chk("tx_word", tw & m, g);
			chk("oe_n_one_word", 32'h00000000, cnt);
			repeat (8) @(posedge clk_sys);
			rchk("rx_ready", `BSP_A_STAT, {13'h0000, s, 1'b1});
			rchk("rx_lo", `BSP_A_RXLO, rw[15:0]);
			rchk("rx_hi", `BSP_A_RXHI, rw[31:16]);
			rchk("rx_ready_clr", `BSP_A_STAT, {13'h0000, s, 1'b0});
		end
		// in clock stop the master bit alone decides both clock pin roles
		wr(`BSP_A_CTRL, 16'h0006);
		repeat (2) @(posedge clk_sys);
		#1 chk("spi_master_oe_n", 32'h00000000, {30'h0, rx_oe_n, tx_oe_n});
		wr(`BSP_A_CTRL, 16'h0002);
		repeat (2) @(posedge clk_sys);
		#1 chk("spi_slave_oe_n", 32'h00000003, {30'h0, rx_oe_n, tx_oe_n});
		// channel 0 and 40 receive, channel 40 transmit, filler channels disabled
		wr(`BSP_A_CTRL, 16'h0000);
		wr({`BSP_A_RXCE, 3'h2}, 16'h0100);
		wr({`BSP_A_TXCE, 3'h0}, 16'h0000);
		wr({`BSP_A_TXCE, 3'h2}, 16'h0100);
		v = '0;
		for (int i = 0; i < 8; i++) v[i] = 8'h5A >> (7 - i);
		for (int i = 8; i < 320; i++) v[i] = i[0];
		for (int i = 0; i < 8; i++) v[i + 320] = 8'hA3 >> (7 - i);
		for (int w = 0; w < 2; w++) begin
			wr(`BSP_A_CTRL, 16'h0000);
			wr(`BSP_A_MC1, {6'h00, w[0], 9'h000});
			wr(`BSP_A_MC2, {6'h00, w[0], 9'h000});
			rchk("wide_en", `BSP_A_MC1, {6'h00, w[0], 9'h000});
			wr(`BSP_A_TXHI, 16'h0000);
			wr(`BSP_A_TXLO, 16'h00C6);
			wr(`BSP_A_CTRL, 16'h0001);
			i_peer.frame(328, v);
			g = '0;
			for (int i = 320; i < 328; i++) g = {g[30:0], i_peer.q[i]};
			chk("ch40_tx", w[0] ? 32'h000000C6 : 32'h00000000, g);
			chk("ch40_oe_n", {31'h0, ~w[0]}, {31'h0, i_peer.e[320]});
			chk("ch0_oe_n", 32'h00000001, {31'h0, i_peer.e[0]});
			g = '0;
			for (int i = 0; i < 8; i++) g = {g[30:0], i_peer.q[i]};
			chk("ch0_tx", 32'h00000000, g);
			repeat (8) @(posedge clk_sys);
			rchk("rx_chan", `BSP_A_RXLO, w[0] ? 16'h00A3 : 16'h005A);
		end
		tally_and_finish();
	end
endmodule : bsp_top_tb
`default_nettype wire
